// ===== hdl/sar_readout.sv
`timescale 1ns/1ps
// Notes on behaviour
// - sdi high at start rise: select mode
// - result word is two's complement
// - start rise floats output, samples, converts
// - conversion runs on, start pin ignored
// - end with busy: acquire, drive low bit
// - msb first, one bit per falling edge
// - 3-wire busy: float after 17 or start rise
// - 4-wire: start rise with sdi high converts
// - start and sdi high at end suppress busy bit
// - sdi fall unfloats with msb, then shifts
// - 4-wire no busy: float after 16 or sdi rise
// - sdi low at end gives busy bit
// - 4-wire busy: float after 17 or sdi rise
// - sdi low at start rise: daisy chain
// - both pins low: output driven low
// - daisy end: load word, show msb
// - daisy: each fall shifts sdi in
module sar_readout (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic convert_start_pin,
  input wire logic sdi_pin,
  input wire logic [sar_pkg::DATA_W-1:0] analog_code,
  output logic dout_o,
  output logic dout_oe,
  output logic converting,
  output logic powered_down
);
  // ---------------- link side, clocked by sclk falling edges ----------------

  // link-side state: reset synchroniser, edge counter, serial-in history
  typedef struct packed {
    logic rst1;
    logic rst2;
    logic [sar_pkg::CNT_W-1:0] cnt;
    logic [sar_pkg::CNT_W-1:0] cnt_gray;
    logic [sar_pkg::DATA_W-1:0] hist;
  } sar_link_t;

  sar_link_t lk_reg; // link-side registers
  sar_link_t lk_next; // link-side next value

  // count edges and capture the serial input on every falling edge
  always_comb begin
    lk_next = lk_reg;
    lk_next.rst1 = resetn;
    lk_next.rst2 = lk_reg.rst1;
    if (!lk_reg.rst2) begin
      // held in reset until the host has given a few edges
      lk_next.cnt = sar_pkg::CNT_ZERO;
      lk_next.cnt_gray = sar_pkg::CNT_ZERO;
      lk_next.hist = sar_pkg::WORD_ZERO;
    end else begin
      lk_next.cnt = lk_reg.cnt + sar_pkg::CNT_ONE;
      // gray copy lets the core read the count one bit change at a time
      lk_next.cnt_gray = lk_next.cnt ^ (lk_next.cnt >> 1);
      lk_next.hist = {lk_reg.hist[sar_pkg::DATA_W-2:0], sdi_pin};
    end
  end

  // link registers run on sclk falling edges only
  always_ff @(negedge sclk) begin
    lk_reg <= lk_next;
  end

  // ---------------- pin and count synchronisers into the core ----------------

  logic start_s; // synchronised start pin
  logic sdi_s; // synchronised select / serial-in pin
  logic [sar_pkg::CNT_W-1:0] gray_s; // synchronised gray edge count

  sar_sync #(
    .W(2)
  ) u_pin_sync (
    .clk(clk),
    .d({convert_start_pin, sdi_pin}),
    .q({start_s, sdi_s})
  );

  sar_sync #(
    .W(sar_pkg::CNT_W)
  ) u_cnt_sync (
    .clk(clk),
    .d(lk_reg.cnt_gray),
    .q(gray_s)
  );

  // gray back to binary
  function automatic logic [sar_pkg::CNT_W-1:0] gray2bin(
    input logic [sar_pkg::CNT_W-1:0] g
  );
    logic [sar_pkg::CNT_W-1:0] b;
    b = g;
    for (int i = sar_pkg::CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  logic [sar_pkg::CNT_W-1:0] cnt_core; // edge count as the core sees it
  assign cnt_core = gray2bin(gray_s);

  // ---------------- core side, clocked by clk ----------------

  // core state: sequencing, mode, result and read window
  typedef struct packed {
    sar_pkg::sar_state_t st;
    logic [sar_pkg::CONV_CNT_W-1:0] conv_cnt;
    logic [sar_pkg::DATA_W-1:0] sample;
    logic [sar_pkg::DATA_W-1:0] result;
    logic cs_mode;
    logic busy_bit;
    sar_pkg::sar_sel_t sel;
    logic out_en;
    logic [sar_pkg::CNT_W-1:0] base;
    logic start_d;
    logic sdi_d;
    logic force_low;
  } sar_core_t;

  sar_core_t cr_reg; // core registers
  sar_core_t cr_next; // core next value

  logic start_rise; // start pin rising edge
  logic start_fall; // start pin falling edge
  logic sdi_rise; // select pin rising edge
  logic sdi_fall; // select pin falling edge

  assign start_rise = start_s && !cr_reg.start_d;
  assign start_fall = !start_s && cr_reg.start_d;
  assign sdi_rise = sdi_s && !cr_reg.sdi_d;
  assign sdi_fall = !sdi_s && cr_reg.sdi_d;

  // sequencing: start, run the conversion, open and close the read window
  always_comb begin
    cr_next = cr_reg;
    cr_next.start_d = start_s;
    cr_next.sdi_d = sdi_s;
    cr_next.force_low = !start_s && !sdi_s;
    case (cr_reg.st)
      sar_pkg::SAR_ST_ACQ: begin
        if (start_rise) begin
          // new sample; output floats at once
          cr_next.st = sar_pkg::SAR_ST_CONV;
          cr_next.sample = analog_code;
          cr_next.cs_mode = sdi_s;
          cr_next.out_en = 1'b0;
          cr_next.busy_bit = 1'b0;
          cr_next.conv_cnt = sar_pkg::CONV_ZERO;
        end else if (cr_reg.cs_mode && !cr_reg.busy_bit) begin
          // no busy bit: chip select edges steer the window
          if (!cr_reg.out_en && start_fall) begin
            cr_next.out_en = 1'b1; // 3-wire read opens on the start fall
            cr_next.sel = sar_pkg::SAR_SEL_START;
            cr_next.base = cnt_core;
          end else if (!cr_reg.out_en && sdi_fall) begin
            cr_next.out_en = 1'b1;
            cr_next.sel = sar_pkg::SAR_SEL_SDI;
            cr_next.base = cnt_core;
          end else if (cr_reg.out_en && cr_reg.sel == sar_pkg::SAR_SEL_SDI && sdi_rise) begin
            cr_next.out_en = 1'b0;
          end
        end else if (cr_reg.cs_mode && cr_reg.busy_bit) begin
          // busy bit: the pin held low during conversion ends the read
          if (cr_reg.sel == sar_pkg::SAR_SEL_SDI && sdi_rise) begin
            cr_next.out_en = 1'b0;
          end
        end
      end
      sar_pkg::SAR_ST_CONV: begin
        // the start pin is not watched here, so a conversion always finishes
        if (cr_reg.conv_cnt == sar_pkg::CONV_LAST) begin
          cr_next.st = sar_pkg::SAR_ST_ACQ;
          cr_next.result = cr_reg.sample;
          cr_next.base = cnt_core;
          if (!cr_reg.cs_mode) begin
            // daisy chain: word loaded, msb shown right away
            cr_next.out_en = 1'b1;
            cr_next.busy_bit = 1'b0;
          end else if (!start_s) begin
            // start pin low at the end: 3-wire with busy
            cr_next.busy_bit = 1'b1;
            cr_next.out_en = 1'b1;
            cr_next.sel = sar_pkg::SAR_SEL_START;
          end else if (!sdi_s) begin
            cr_next.busy_bit = 1'b1;
            cr_next.out_en = 1'b1;
            cr_next.sel = sar_pkg::SAR_SEL_SDI;
          end else begin
            cr_next.busy_bit = 1'b0;
            cr_next.out_en = 1'b0;
          end
        end else begin
          cr_next.conv_cnt = cr_reg.conv_cnt + 8'h01;
        end
      end
      default: begin
        cr_next.st = sar_pkg::SAR_ST_ACQ;
      end
    endcase
  end

  // core registers with synchronous active-low reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cr_reg.st <= sar_pkg::SAR_ST_ACQ;
      cr_reg.conv_cnt <= sar_pkg::CONV_ZERO;
      cr_reg.sample <= sar_pkg::WORD_ZERO;
      cr_reg.result <= sar_pkg::WORD_ZERO;
      cr_reg.cs_mode <= 1'b1;
      cr_reg.busy_bit <= 1'b0;
      cr_reg.sel <= sar_pkg::SAR_SEL_START;
      cr_reg.out_en <= 1'b0;
      cr_reg.base <= sar_pkg::CNT_ZERO;
      cr_reg.start_d <= 1'b0;
      cr_reg.sdi_d <= 1'b0;
      cr_reg.force_low <= 1'b0;
    end else begin
      cr_reg <= cr_next;
    end
  end

  // ---------------- output selection ----------------
  // the core-side base and result stay still for the whole read, so the
  // link-side count can index them directly; the difference k is the
  // number of falling edges since the read window opened

  logic [sar_pkg::CNT_W-1:0] k; // edges since the window opened
  logic [4:0] pos; // bit position inside the result
  logic win_open; // window still within its edge limit
  logic bit_val; // bit presented while driven

  assign k = lk_reg.cnt - cr_reg.base;

  // choose bit and window for the active mode
  always_comb begin
    pos = sar_pkg::MSB_POS;
    bit_val = 1'b0;
    win_open = 1'b0;
    if (!cr_reg.cs_mode) begin
      // daisy chain: own word first, then the neighbour's bits
      win_open = cr_reg.out_en;
      if (k < sar_pkg::EDGES_DATA) begin
        pos = sar_pkg::MSB_POS - 5'(k);
        bit_val = cr_reg.result[pos[3:0]];
      end else begin
        bit_val = lk_reg.hist[sar_pkg::DATA_W-1];
      end
    end else if (cr_reg.busy_bit) begin
      // low busy bit, then the data msb first
      win_open = cr_reg.out_en && (k < sar_pkg::EDGES_BUSY);
      if (k == sar_pkg::CNT_ZERO) begin
        bit_val = 1'b0;
      end else begin
        pos = sar_pkg::BUSY_POS - 5'(k);
        bit_val = cr_reg.result[pos[3:0]];
      end
    end else begin
      win_open = cr_reg.out_en && (k < sar_pkg::EDGES_DATA);
      pos = sar_pkg::MSB_POS - 5'(k);
      bit_val = cr_reg.result[pos[3:0]];
    end
  end

  // the 3-wire read also ends at once on a start rise, before the core sees it
  logic start_stop; // start pin high ends a start-pin read
  assign start_stop = (cr_reg.sel == sar_pkg::SAR_SEL_START) && start_s;

  // both pins low overrides everything with a driven low level
  assign dout_oe = cr_reg.force_low || (win_open && !start_stop && cr_reg.cs_mode)
                   || (win_open && !cr_reg.cs_mode);
  assign dout_o = cr_reg.force_low ? 1'b0 : bit_val;

  // status for the surrounding chip
  assign converting = (cr_reg.st == sar_pkg::SAR_ST_CONV);
  assign powered_down = (cr_reg.st == sar_pkg::SAR_ST_ACQ);
endmodule

// ===== hdl/sar_pkg.sv
package sar_pkg;
  // word width of one conversion result
  localparam int DATA_W = 16;
  // width of the free-running sclk falling-edge counter; wide enough for long chains
  localparam int CNT_W = 12;
  // core clock period and modelled conversion time
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS = 700;
  // conversion length in core cycles, rounded down, never below one
  localparam int CONV_CYCLES_RAW = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
  localparam int CONV_CNT_W = 8;
  localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - 1);
  localparam logic [CONV_CNT_W-1:0] CONV_ZERO = 8'h00;
  // falling edges after which the output floats
  localparam logic [CNT_W-1:0] EDGES_DATA = 12'h010;
  localparam logic [CNT_W-1:0] EDGES_BUSY = 12'h011;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  // bit positions inside the result word
  localparam logic [4:0] MSB_POS = 5'h0F;
  localparam logic [4:0] BUSY_POS = 5'h10;
  localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;

  // core-side sequencing states
  typedef enum logic [1:0] {
    SAR_ST_ACQ = 2'b00,
    SAR_ST_CONV = 2'b01
  } sar_state_t;

  // which pin acts as chip select during a read
  typedef enum logic {
    SAR_SEL_START = 1'b0,
    SAR_SEL_SDI = 1'b1
  } sar_sel_t;
endpackage

// ===== hdl/sar_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser; only the second stage is visible outside
module sar_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // both stages in one state word
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sar_sync_t;

  sar_sync_t st_reg; // registered stages
  sar_sync_t st_next; // next stages

  // shift the input one stage per edge
  always_comb begin
    st_next = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  // no reset: contents settle within two edges
  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign q = st_reg.s2;
endmodule

// ===== tb/sar_readout_sva.sv
`timescale 1ns/1ps
// pin-level checks of the readout block
module sar_readout_sva (
  input logic clk,
  input logic resetn,
  input logic sclk,
  input logic convert_start_pin,
  input logic sdi_pin,
  input logic [sar_pkg::DATA_W-1:0] analog_code,
  input logic dout_o,
  input logic dout_oe,
  input logic converting,
  input logic powered_down
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic start_d; // start level one edge back
  logic conv_d; // converting one edge back
  logic cs_mode; // select level at the last start rise
  logic [sar_pkg::DATA_W-1:0] code_q; // word under conversion
  // mode and word rebuilt from the pins, not taken from the block
  always_ff @(posedge clk) begin
    start_d <= convert_start_pin;
    conv_d <= converting;
    if (convert_start_pin && !start_d) begin
      cs_mode <= sdi_pin;
    end
    if (converting && !conv_d) begin
      code_q <= analog_code;
    end
  end
  sequence s_conv_run;
    converting [*8] ##5 converting;
  endsequence
  sequence s_both_low;
    (!convert_start_pin && !sdi_pin) [*5];
  endsequence
  chk_conv_len: assert property ($rose(converting) |-> s_conv_run ##[1:3] !converting)
    else $error("bad conversion length");
  chk_conv_go: assert property ($rose(convert_start_pin) && !converting |-> ##[1:6] converting)
    else $error("conversion did not start");
  chk_start_float: assert property ($rose(convert_start_pin) |-> ##[0:6] !dout_oe)
    else $error("no float on start rise");
  chk_power_state: assert property (converting != powered_down)
    else $error("power state wrong");
  chk_busy_low: assert property ($fell(converting) && cs_mode && !convert_start_pin
      |-> ##[0:2] (dout_oe && !dout_o))
    else $error("busy bit missing");
  chk_busy_none: assert property ($fell(converting) && cs_mode && sdi_pin
      && convert_start_pin |-> !dout_oe [*4])
    else $error("busy bit not suppressed");
  chk_daisy_msb: assert property ($fell(converting) && !cs_mode
      |-> ##[0:2] (dout_oe && dout_o == code_q[sar_pkg::DATA_W-1]))
    else $error("chain msb missing");
  chk_both_low: assert property (s_both_low |-> dout_oe && !dout_o)
    else $error("line not driven low");
  chk_sdi_float: assert property ($rose(sdi_pin) && cs_mode && convert_start_pin
      |-> ##[1:5] !dout_oe)
    else $error("no float on select rise");
endmodule
bind sar_readout sar_readout_sva u_sva (
  .clk(clk), .resetn(resetn), .sclk(sclk),
  .convert_start_pin(convert_start_pin), .sdi_pin(sdi_pin),
  .analog_code(analog_code), .dout_o(dout_o), .dout_oe(dout_oe),
  .converting(converting), .powered_down(powered_down)
);

// ===== tb/sar_host_model.sv
`timescale 1ns/1ps
// host end of the link: sclk bursts, line read mid-bit
module sar_host_model (
  input logic line,
  output logic sclk,
  output logic feed,
  output logic [31:0] got
);
  // sclk rests low, so no start rise sees it high
  initial begin
    sclk = 1'b0;
    feed = 1'b0;
    got = 32'h00000000;
  end
  // n falls at the link rate; rise read keeps clear of the shift
  task automatic burst(input int n, input logic [31:0] pat);
    got = 32'h00000000;
    #3.1;
    for (int i = 0; i < n; i++) begin
      #7.5;
      sclk = 1'b1;
      got = {got[30:0], line};
      feed = pat[31-i];
      #7.5;
      sclk = 1'b0;
    end
    // released feed must not look like held data
    #7.5;
    feed = ~feed;
  endtask
endmodule

// ===== tb/sar_readout_tb.sv
`timescale 1ns/1ps
`define CHK(e, a) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    bad_count++; \
    $display("ERROR at %0t: expected %h got %h", $time, e, a); \
  end \
end
// host-side bench of the readout block
module sar_readout_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0; // start pin
  logic sdi_r = 1'b1; // select pin as driven here
  logic chain = 1'b0; // hands sdi to the host feed in chain reads
  logic [15:0] analog_code = 16'h0000;
  logic [15:0] code;
  logic [15:0] p;
  logic sclk, feed, dout_o, dout_oe, converting, powered_down;
  logic [31:0] got, res, e;
  logic [31:0] exp_q[$];
  event res_e;
  int bad_count = 0;
  int comparisons = 0;
  wire line = dout_oe ? dout_o : 1'b1; // pull-up on the data line
  wire sdi_pin = chain ? feed : sdi_r;
  sar_readout u_sar_readout (
    .clk(clk), .resetn(resetn), .sclk(sclk),
    .convert_start_pin(start), .sdi_pin(sdi_pin), .analog_code(analog_code),
    .dout_o(dout_o), .dout_oe(dout_oe), .converting(converting),
    .powered_down(powered_down)
  );
  sar_host_model u_host (.line(line), .sclk(sclk), .feed(feed), .got(got));
  always #25 clk = ~clk;
  // takes the oldest note whenever a result appears
  always @(res_e) begin
    e = exp_q.pop_front();
    `CHK(e, res)
  end
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic note(input logic [31:0] v);
    exp_q.push_back(v);
  endtask
  task automatic show(input logic [31:0] a);
    res = a;
    -> res_e;
    #1;
  endtask
  // line masked while floated, its level is meaningless then
  task automatic status();
    #10;
    show({28'h0000000, dout_oe, dout_oe & dout_o, converting, powered_down});
  endtask
  task automatic pins(input logic c, input logic s, input int n);
    @(posedge clk);
    start <= c;
    sdi_r <= s;
    repeat (n) @(posedge clk);
  endtask
  // start rise, then the levels that pick the end behaviour
  task automatic conv(input logic c, input logic s);
    code = 16'($urandom);
    @(posedge clk);
    analog_code <= code;
    pins(1'b1, sdi_r, 6);
    pins(c, s, 20);
  endtask
  task automatic read(input int n, input logic [31:0] pat);
    u_host.burst(n, pat);
    show(got);
  endtask
  initial begin
    void'($urandom(92));
    u_host.burst(4, 32'h00000000);
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    // link reset only leaves on sclk falls; flush it before the first read
    u_host.burst(4, 32'h00000000);
    // three-wire with busy bit
    conv(1'b0, 1'b1);
    note(32'h00000009);
    status();
    note({12'h000, 1'h0, code, 3'h7});
    read(20, 32'h00000000);
    // four-wire with busy bit
    conv(1'b1, 1'b0);
    note(32'h00000009);
    status();
    note({12'h000, 1'h0, code, 3'h7});
    read(20, 32'h00000000);
    pins(1'b1, 1'b1, 4);
    pins(1'b0, 1'b1, 4);
    // four-wire without busy bit, select falls to read
    conv(1'b1, 1'b1);
    note(32'h00000001);
    status();
    pins(1'b1, 1'b0, 5);
    note({12'h000, code, 4'hF});
    read(20, 32'h00000000);
    pins(1'b1, 1'b1, 4);
    // chain: both low first, then 32 falls through one stage
    pins(1'b1, 1'b0, 2);
    pins(1'b0, 1'b0, 6);
    note(32'h00000009);
    status();
    conv(1'b1, 1'b0);
    note({28'h0000000, 1'h1, code[15], 1'h0, 1'h1});
    status();
    p = 16'($urandom);
    chain <= 1'b1;
    note({code, p});
    read(32, {p, 16'h0000});
    chain <= 1'b0;
    pins(1'b1, 1'b1, 3);
    pins(1'b0, 1'b1, 3);
    test_done();
  end
  // whole run is near 10 us
  initial begin
    #100000;
    bad_count++;
    test_done();
  end
endmodule
